/* hdl/pdoec_pkg.sv */
// package: register map, field positions and reset values of the pad enable control
package pdoec_pkg;
  // register offsets (word index on the plain register port)
  localparam logic [3:0] PAD_CTRL_OFS     = 4'h0;  // external_bus_control_reg
  localparam logic [3:0] CLK_HIZ_OFS      = 4'h1;  // clock_out_hiz_select bits
  localparam logic [3:0] GP_DIR_OFS       = 4'h2;  // general-purpose direction
  localparam logic [3:0] GP_OUT_OFS       = 4'h3;  // general-purpose output value
  localparam logic [3:0] GP_IN_OFS        = 4'h4;  // general-purpose input value
  localparam logic [3:0] STATUS_OFS       = 4'h5;  // pad mode status
  localparam logic [3:0] GP_SEL_OFS       = 4'h6;  // general-purpose function select
  // field positions in the external bus control register
  localparam int HOLDER_EN_POS   = 0;
  localparam int PULLUP_EN_POS   = 1;
  localparam int PULLDOWN_EN_POS = 2;
  localparam int EMU_PULLUP_POS  = 3;
  // field positions in the status register
  localparam int ST_OFF_POS      = 0;
  localparam int ST_HOLD_POS     = 1;
  localparam int ST_TEST_POS     = 2;
  // reset values
  localparam logic [3:0]  PAD_CTRL_RST = 4'hf;   // holder, pull-up, pull-down enabled
  localparam logic [1:0]  CLK_HIZ_RST  = 2'h0;   // memory clocks keep running in hold
  localparam logic [15:0] GP_RST       = 16'h0000;
  // pad mode of the device
  typedef enum logic [1:0] {
    PDOEC_RUN,
    PDOEC_RESET,
    PDOEC_HOLD,
    PDOEC_OFF
  } pdoec_mode_t;
endpackage : pdoec_pkg

/* hdl/pdoec_regs.sv */
// register file of the pad enable control, plain strobe port
`timescale 1ns/1ps
module pdoec_regs #(
  parameter int GP_W = 16
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // state read back
  input  wire logic [GP_W-1:0]      gp_in_val,
  input  wire logic [2:0]           mode_status,
  // control out
  output logic      [3:0]           ctrl_ff,
  output logic      [1:0]           clk_hiz_ff,
  output logic      [GP_W-1:0]      gp_dir_ff,
  output logic      [GP_W-1:0]      gp_out_ff,
  output logic      [GP_W-1:0]      gp_sel_ff
);
  logic [3:0]      nxt_ctrl;
  logic [1:0]      nxt_clk_hiz;
  logic [GP_W-1:0] nxt_gp_dir;
  logic [GP_W-1:0] nxt_gp_out;
  logic [GP_W-1:0] nxt_gp_sel;
  logic [31:0]     nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // write decode and read mux
  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_clk_hiz = clk_hiz_ff;
    nxt_gp_dir  = gp_dir_ff;
    nxt_gp_out  = gp_out_ff;
    nxt_gp_sel  = gp_sel_ff;
    nxt_rdata   = 32'h0000_0000;
    if (reg_wr)
    begin
      if (reg_addr == pdoec_pkg::PAD_CTRL_OFS)
        nxt_ctrl = reg_wdata[3:0];
      else if (reg_addr == pdoec_pkg::CLK_HIZ_OFS)
        nxt_clk_hiz = reg_wdata[1:0];
      else if (reg_addr == pdoec_pkg::GP_DIR_OFS)
        nxt_gp_dir = reg_wdata[GP_W-1:0];
      else if (reg_addr == pdoec_pkg::GP_OUT_OFS)
        nxt_gp_out = reg_wdata[GP_W-1:0];
      else if (reg_addr == pdoec_pkg::GP_SEL_OFS)
        nxt_gp_sel = reg_wdata[GP_W-1:0];
    end
    if (reg_rd)
    begin
      if (reg_addr == pdoec_pkg::PAD_CTRL_OFS)
        nxt_rdata = {28'h0, ctrl_ff};
      else if (reg_addr == pdoec_pkg::CLK_HIZ_OFS)
        nxt_rdata = {30'h0, clk_hiz_ff};
      else if (reg_addr == pdoec_pkg::GP_DIR_OFS)
        nxt_rdata[GP_W-1:0] = gp_dir_ff;
      else if (reg_addr == pdoec_pkg::GP_OUT_OFS)
        nxt_rdata[GP_W-1:0] = gp_out_ff;
      else if (reg_addr == pdoec_pkg::GP_IN_OFS)
        nxt_rdata[GP_W-1:0] = gp_in_val;
      else if (reg_addr == pdoec_pkg::STATUS_OFS)
        nxt_rdata = {29'h0, mode_status};
      else if (reg_addr == pdoec_pkg::GP_SEL_OFS)
        nxt_rdata[GP_W-1:0] = gp_sel_ff;
    end
  end

  // register stage, defaults enable holder and pulls
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrl_ff    <= pdoec_pkg::PAD_CTRL_RST;
      clk_hiz_ff <= pdoec_pkg::CLK_HIZ_RST;
      gp_dir_ff  <= pdoec_pkg::GP_RST;
      gp_out_ff  <= pdoec_pkg::GP_RST;
      gp_sel_ff  <= pdoec_pkg::GP_RST;
      reg_rdata  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      clk_hiz_ff <= nxt_clk_hiz;
      gp_dir_ff  <= nxt_gp_dir;
      gp_out_ff  <= nxt_gp_out;
      gp_sel_ff  <= nxt_gp_sel;
      reg_rdata  <= nxt_rdata;
    end
  end
endmodule : pdoec_regs

/* hdl/pdoec_clkdiv.sv */
// divider producing the memory clock output level from the core clock
`timescale 1ns/1ps
module pdoec_clkdiv #(
  parameter int DIV = 2
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // divided clock level
  output logic      mclk_ff
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          nxt_mclk;

  // count half periods and toggle
  always_comb
  begin
    nxt_cnt  = cnt_ff + 1'b1;
    nxt_mclk = mclk_ff;
    if (cnt_ff == CW'(DIV - 1))
    begin
      nxt_cnt  = '0;
      nxt_mclk = ~mclk_ff;
    end
  end

  // register stage
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cnt_ff  <= '0;
      mclk_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      mclk_ff <= nxt_mclk;
    end
  end
endmodule : pdoec_clkdiv

/* hdl/pdoec_top.sv */
// pad output enable control: off, hold, reset tristate, pulls and gpio
`timescale 1ns/1ps
// What this block does
// - test reset low, line0 high, line1 low: off
// - test reset high: emulation lines are interrupts
// - bus pins float while hold is requested
// - hiz select zero keeps memory clock running
// - hiz select one floats memory clock in hold
// - bus holder software switchable, enabled after reset
// - pull-up software switchable, enabled by default
// - pull-down software switchable, enabled by default
// - reset-tristated pins float while reset low
// - gpio pins selectable input or output
module pdoec_top #(
  parameter int BUS_W    = 16,
  parameter int GP_W     = 16,
  parameter int CLK_DIV  = 2
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // test and emulation pins
  input  wire logic              test_reset_n,
  input  wire logic              emulation_line_zero_i,
  output logic                   emulation_line_zero_o,
  output logic                   emulation_line_zero_oe,
  input  wire logic              emulation_line_one_output_disable_i,
  output logic                   emulation_line_one_output_disable_o,
  output logic                   emulation_line_one_output_disable_oe,
  // emulation interrupt side, direction from the scan system
  input  wire logic              emu_int_out0,
  input  wire logic              emu_int_out1,
  input  wire logic              scan_drive0,
  input  wire logic              scan_drive1,
  output logic                   emu_int_in0,
  output logic                   emu_int_in1,
  // hold request
  input  wire logic              hold_req,
  // bus pins: functional drive in, pad enables out
  input  wire logic [BUS_W-1:0]  bus_func_o,
  input  wire logic [BUS_W-1:0]  bus_func_oe,
  output logic      [BUS_W-1:0]  bus_pad_o,
  output logic      [BUS_W-1:0]  bus_pad_oe,
  // memory clock outputs
  output logic      [1:0]        memory_clock_output_o,
  output logic      [1:0]        memory_clock_output_oe,
  // general-purpose pins and their shared function
  input  wire logic [GP_W-1:0]   gp_pad_i,
  input  wire logic [GP_W-1:0]   gp_func_o,
  input  wire logic [GP_W-1:0]   gp_func_oe,
  output logic      [GP_W-1:0]   gp_pad_o,
  output logic      [GP_W-1:0]   gp_pad_oe,
  // pad keeper and pull controls
  output logic                   holder_en,
  output logic                   pullup_en,
  output logic                   pulldown_en,
  output logic                   emu_pullup_en
);
  ////////////////////////////////////////////////////////////////////////////
  // register file and clock divider
  logic [3:0]      ctrl_ff;
  logic [1:0]      clk_hiz_ff;
  logic [GP_W-1:0] gp_dir_ff;
  logic [GP_W-1:0] gp_out_ff;
  logic [GP_W-1:0] gp_sel_ff;
  logic [GP_W-1:0] gp_in_ff;
  logic [2:0]      mode_status;
  logic            mclk_ff;
  pdoec_pkg::pdoec_mode_t mode_ff;
  pdoec_pkg::pdoec_mode_t nxt_mode;

  pdoec_regs #(
    .GP_W        (GP_W)
  ) u_regs (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .gp_in_val   (gp_in_ff),
    .mode_status (mode_status),
    .ctrl_ff     (ctrl_ff),
    .clk_hiz_ff  (clk_hiz_ff),
    .gp_dir_ff   (gp_dir_ff),
    .gp_out_ff   (gp_out_ff),
    .gp_sel_ff   (gp_sel_ff)
  );

  pdoec_clkdiv #(
    .DIV      (CLK_DIV)
  ) u_clkdiv (
    .core_clk (core_clk),
    .nrst     (nrst),
    .mclk_ff  (mclk_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pad mode decode, off has highest priority
  logic off_cond;
  assign off_cond = !test_reset_n && emulation_line_zero_i
                    && !emulation_line_one_output_disable_i;

  always_comb
  begin
    if (off_cond)
      nxt_mode = pdoec_pkg::PDOEC_OFF;
    else if (hold_req)
      nxt_mode = pdoec_pkg::PDOEC_HOLD;
    else
      nxt_mode = pdoec_pkg::PDOEC_RUN;
  end

  // mode register, loads the reset state in reset; only the status bits read it
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      mode_ff <= pdoec_pkg::PDOEC_RESET;
    else
      mode_ff <= nxt_mode;
  end

  // status bits for software
  always_comb
  begin
    mode_status = 3'h0;
    mode_status[pdoec_pkg::ST_OFF_POS]  = (mode_ff == pdoec_pkg::PDOEC_OFF);
    mode_status[pdoec_pkg::ST_HOLD_POS] = (mode_ff == pdoec_pkg::PDOEC_HOLD);
    mode_status[pdoec_pkg::ST_TEST_POS] = test_reset_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next pad values
  logic [BUS_W-1:0] nxt_bus_o;
  logic [BUS_W-1:0] nxt_bus_oe;
  logic [GP_W-1:0]  nxt_gp_o;
  logic [GP_W-1:0]  nxt_gp_oe;
  logic [GP_W-1:0]  gp_want_oe;
  logic [1:0]       nxt_mclk_oe;
  logic             nxt_emulation_line_zero_oe;
  logic             nxt_emu1_oe;
  logic             run_mode;
  logic             hold_mode;

  assign run_mode  = (nxt_mode == pdoec_pkg::PDOEC_RUN) && nrst;
  assign hold_mode = (nxt_mode == pdoec_pkg::PDOEC_HOLD) && nrst;

  // per-pin gpio choice: software direction or shared function
  genvar gi;
  generate
    for (gi = 0; gi < GP_W; gi++)
    begin : g_gp
      assign nxt_gp_o[gi]   = gp_sel_ff[gi] ? gp_out_ff[gi] : gp_func_o[gi];
      assign gp_want_oe[gi] = gp_sel_ff[gi] ? gp_dir_ff[gi] : gp_func_oe[gi];
    end
  endgenerate

  always_comb
  begin
    nxt_bus_o   = bus_func_o;
    nxt_bus_oe  = '0;
    nxt_gp_oe   = '0;
    nxt_mclk_oe = 2'b00;
    nxt_emulation_line_zero_oe = 1'b0;
    nxt_emu1_oe = 1'b0;
    if (run_mode)
    begin
      nxt_bus_oe  = bus_func_oe;
      nxt_gp_oe   = gp_want_oe;
      nxt_mclk_oe = 2'b11;
    end
    else if (hold_mode)
    begin
      nxt_bus_oe  = '0;
      nxt_gp_oe   = gp_want_oe;
      nxt_mclk_oe = ~clk_hiz_ff;
    end
    if (test_reset_n && nrst)
    begin
      nxt_emulation_line_zero_oe = scan_drive0;
      nxt_emu1_oe = scan_drive1;
    end
  end

  // pad registers, every output enable low in reset and off, holder and pull enables high in reset
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bus_pad_o                            <= '0;
      bus_pad_oe                           <= '0;
      gp_pad_o                             <= '0;
      gp_pad_oe                            <= '0;
      gp_in_ff                             <= '0;
      memory_clock_output_o                <= 2'b00;
      memory_clock_output_oe               <= 2'b00;
      emulation_line_zero_o                <= 1'b0;
      emulation_line_zero_oe               <= 1'b0;
      emulation_line_one_output_disable_o  <= 1'b0;
      emulation_line_one_output_disable_oe <= 1'b0;
      emu_int_in0                          <= 1'b0;
      emu_int_in1                          <= 1'b0;
      holder_en                            <= 1'b1;
      pullup_en                            <= 1'b1;
      pulldown_en                          <= 1'b1;
      emu_pullup_en                        <= 1'b1;
    end
    else
    begin
      bus_pad_o                            <= nxt_bus_o;
      bus_pad_oe                           <= nxt_bus_oe;
      gp_pad_o                             <= nxt_gp_o;
      gp_pad_oe                            <= nxt_gp_oe;
      gp_in_ff                             <= gp_pad_i;
      memory_clock_output_o                <= {2{mclk_ff}};
      memory_clock_output_oe               <= nxt_mclk_oe;
      emulation_line_zero_o                <= emu_int_out0;
      emulation_line_zero_oe               <= nxt_emulation_line_zero_oe;
      emulation_line_one_output_disable_o  <= emu_int_out1;
      emulation_line_one_output_disable_oe <= nxt_emu1_oe;
      emu_int_in0                          <= test_reset_n & emulation_line_zero_i;
      emu_int_in1                          <= test_reset_n
                                              & emulation_line_one_output_disable_i;
      holder_en     <= ctrl_ff[pdoec_pkg::HOLDER_EN_POS];
      pullup_en     <= ctrl_ff[pdoec_pkg::PULLUP_EN_POS];
      pulldown_en   <= ctrl_ff[pdoec_pkg::PULLDOWN_EN_POS];
      emu_pullup_en <= ctrl_ff[pdoec_pkg::EMU_PULLUP_POS];
    end
  end
endmodule : pdoec_top

/* sim/pdoec_chk.sv */
// checker: pad enable assertions on the top-level ports
`timescale 1ns/1ps
module pdoec_chk #(
  parameter int BUS_W   = 16,
  parameter int GP_W    = 16,
  parameter int CLK_DIV = 2
) (
  // clock and reset
  input wire logic             core_clk,
  input wire logic             nrst,
  // register port
  input wire logic [3:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  // test and emulation
  input wire logic             test_reset_n,
  input wire logic             emulation_line_zero_i,
  input wire logic             emulation_line_zero_oe,
  input wire logic             emulation_line_one_output_disable_i,
  input wire logic             emulation_line_one_output_disable_oe,
  input wire logic             scan_drive0,
  input wire logic             scan_drive1,
  input wire logic             emu_int_in0,
  input wire logic             emu_int_in1,
  // hold and pads
  input wire logic             hold_req,
  input wire logic [BUS_W-1:0] bus_func_oe,
  input wire logic [BUS_W-1:0] bus_pad_oe,
  input wire logic [1:0]       memory_clock_output_o,
  input wire logic [1:0]       memory_clock_output_oe,
  input wire logic [GP_W-1:0]  gp_pad_oe,
  // keeper and pulls
  input wire logic             holder_en,
  input wire logic             pullup_en,
  input wire logic             pulldown_en
);
  logic       off;
  logic [1:0] hiz_sh_ff;
  logic [1:0] nxt_hiz_sh;
  logic [3:0] ctrl_sh_ff;
  logic [3:0] nxt_ctrl_sh;
  logic [2:0] up_cnt_ff;
  logic [2:0] nxt_up_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // off decode and shadows of the software settings
  assign off = !test_reset_n && emulation_line_zero_i && !emulation_line_one_output_disable_i;
  always_comb
  begin
    nxt_hiz_sh  = hiz_sh_ff;
    nxt_ctrl_sh = ctrl_sh_ff;
    nxt_up_cnt  = (up_cnt_ff == 3'h7) ? up_cnt_ff : up_cnt_ff + 3'h1;
    if (reg_wr && reg_addr == pdoec_pkg::CLK_HIZ_OFS) nxt_hiz_sh = reg_wdata[1:0];
    if (reg_wr && reg_addr == pdoec_pkg::PAD_CTRL_OFS) nxt_ctrl_sh = reg_wdata[3:0];
    if (!nrst)
    begin
      nxt_hiz_sh  = pdoec_pkg::CLK_HIZ_RST;
      nxt_ctrl_sh = pdoec_pkg::PAD_CTRL_RST;
      nxt_up_cnt  = 3'h0;
    end
  end
  // shadow registers
  always_ff @(posedge core_clk)
  begin
    hiz_sh_ff  <= nxt_hiz_sh;
    ctrl_sh_ff <= nxt_ctrl_sh;
    up_cnt_ff  <= nxt_up_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_hold_steady;
    (hold_req && !off && !hiz_sh_ff[0] && up_cnt_ff == 3'h7)[*4];
  endsequence
  sequence s_ctrl_quiet;
    ($stable(ctrl_sh_ff))[*3];
  endsequence
  a_off_all_float: assert property (off |=> bus_pad_oe == '0 && gp_pad_oe == '0
    && memory_clock_output_oe == 2'h0) else $error("pads driven in off");
  a_hold_bus_float: assert property (hold_req |=> bus_pad_oe == '0)
    else $error("bus driven in hold");
  a_run_bus_follow: assert property (!hold_req && !off |=> bus_pad_oe == $past(bus_func_oe))
    else $error("bus enable lost outside hold");
  a_hold_clk_sel: assert property (hold_req && !off
    |=> memory_clock_output_oe == ~$past(hiz_sh_ff)) else $error("clock enable in hold");
  a_hold_clk_runs: assert property (s_hold_steady
    |-> memory_clock_output_o[0] != $past(memory_clock_output_o[0], CLK_DIV))
    else $error("memory clock stopped in hold");
  a_emu_dir_scan: assert property (test_reset_n
    |=> emulation_line_zero_oe == $past(scan_drive0)
    && emulation_line_one_output_disable_oe == $past(scan_drive1)) else $error("emu direction");
  a_emu_int_level: assert property (test_reset_n
    |=> emu_int_in0 == $past(emulation_line_zero_i)
    && emu_int_in1 == $past(emulation_line_one_output_disable_i)) else $error("emu level");
  a_reset_pads_float: assert property ($rose(nrst)
    |-> bus_pad_oe == '0 && gp_pad_oe == '0
    && memory_clock_output_oe == 2'h0 && holder_en && pullup_en && pulldown_en)
    else $error("reset pad state");
  a_pull_sw_ctrl: assert property (s_ctrl_quiet |-> holder_en == ctrl_sh_ff[0]
    && pullup_en == ctrl_sh_ff[1] && pulldown_en == ctrl_sh_ff[2]) else $error("pull control");
  a_idle_rdata_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
endmodule : pdoec_chk
bind pdoec_top pdoec_chk #(.BUS_W(BUS_W), .GP_W(GP_W), .CLK_DIV(CLK_DIV)) u_chk (
  .core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .test_reset_n,
  .emulation_line_zero_i, .emulation_line_zero_oe, .emulation_line_one_output_disable_i,
  .emulation_line_one_output_disable_oe, .scan_drive0, .scan_drive1, .emu_int_in0,
  .emu_int_in1, .hold_req, .bus_func_oe, .bus_pad_oe, .memory_clock_output_o,
  .memory_clock_output_oe, .gp_pad_oe, .holder_en, .pullup_en, .pulldown_en);

/* sim/pdoec_emu.sv */
// emulator and test-equipment model on the two emulation lines
`timescale 1ns/1ps
module pdoec_emu (
  // mode: 0 idle, 1 off, 2 emulator drives, 3 test reset only
  input  wire logic [1:0] emu_mode,
  input  wire logic [1:0] emu_val,
  // device side of the lines
  input  wire logic       line0_o,
  input  wire logic       line0_oe,
  input  wire logic       line1_o,
  input  wire logic       line1_oe,
  // resolved levels
  output logic            test_reset_n,
  output logic            line0_lvl,
  output logic            line1_lvl
);
  // test reset low fixes the lines; otherwise device, emulator, then pull-up
  always_comb
  begin
    test_reset_n = !emu_mode[0];
    line0_lvl    = 1'b1;
    line1_lvl    = (emu_mode != 2'h1);
    if (!emu_mode[0])
    begin
      if (line0_oe) line0_lvl = line0_o;
      else if (emu_mode[1]) line0_lvl = emu_val[0];
      if (line1_oe) line1_lvl = line1_o;
      else if (emu_mode[1]) line1_lvl = emu_val[1];
    end
  end
endmodule : pdoec_emu

/* sim/pdoec_bench.sv */
// bench: random and corner pad traffic against the pad enable control
`timescale 1ns/1ps
module pdoec_bench;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        tst_n, l0_i, l1_i, l0_o, l0_oe, l1_o, l1_oe, in0, in1, last;
  logic [1:0]  emu_mode = 2'h0, emu_val = 2'h0, int_out = 2'h0, scan = 2'h0, hiz_r;
  logic        hold_req = 1'b0;
  logic [15:0] bf_o = '0, bf_oe = '0, gi = '0, gf_o = '0, gf_oe = '0, sel_r, dir_r, out_r;
  logic [15:0] bp_o, bp_oe, gp_o, gp_oe;
  logic [1:0]  mc_o, mc_oe;
  logic        hold_en, pu_en, pd_en, epu_en;
  logic [31:0] seed = 32'h6bd0dadb;
  int          fails = 0;
  int          tests_run = 0;
  int          n;
  ////////////////////////////////////////////////////////////////////////////
  // device, emulator model and clock
  pdoec_top #(.CLK_DIV(2)) dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .test_reset_n(tst_n), .emulation_line_zero_i(l0_i),
    .emulation_line_zero_o(l0_o), .emulation_line_zero_oe(l0_oe),
    .emulation_line_one_output_disable_i(l1_i), .emulation_line_one_output_disable_o(l1_o),
    .emulation_line_one_output_disable_oe(l1_oe), .emu_int_out0(int_out[0]),
    .emu_int_out1(int_out[1]), .scan_drive0(scan[0]), .scan_drive1(scan[1]),
    .emu_int_in0(in0), .emu_int_in1(in1), .hold_req, .bus_func_o(bf_o), .bus_func_oe(bf_oe),
    .bus_pad_o(bp_o), .bus_pad_oe(bp_oe), .memory_clock_output_o(mc_o),
    .memory_clock_output_oe(mc_oe), .gp_pad_i(gi), .gp_func_o(gf_o), .gp_func_oe(gf_oe),
    .gp_pad_o(gp_o), .gp_pad_oe(gp_oe), .holder_en(hold_en), .pullup_en(pu_en),
    .pulldown_en(pd_en), .emu_pullup_en(epu_en));
  pdoec_emu emu (.emu_mode, .emu_val, .line0_o(l0_o), .line0_oe(l0_oe), .line1_o(l1_o),
    .line1_oe(l1_oe), .test_reset_n(tst_n), .line0_lvl(l0_i), .line1_lvl(l1_i));
  always #2 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  // helpers: random source, expectation, compare, register cycles, verdict
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [33:0] exp_oe(input logic off, input logic hold,
                                         input logic [15:0] bfoe, input logic [15:0] gfoe);
    if (off) return 34'h0;
    return {hold ? ~hiz_r : 2'h3, hold ? 16'h0 : bfoe, (sel_r & dir_r) | (~sel_r & gfoe)};
  endfunction : exp_oe
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp({2'h0, reg_rdata}, {2'h0, e}, what);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(pdoec_pkg::PAD_CTRL_OFS, 32'(pdoec_pkg::PAD_CTRL_RST), "ctrl reset");
    rd(pdoec_pkg::CLK_HIZ_OFS, 32'h0, "hiz reset");
    rd(pdoec_pkg::GP_SEL_OFS, 32'h0, "select reset");
    rd(4'hf, 32'h0, "unmapped read");
    for (int i = 0; i < 8; i++)
    begin
      wr(pdoec_pkg::PAD_CTRL_OFS, 32'(i));
      settle();
      cmp({30'h0, epu_en, pd_en, pu_en, hold_en}, 34'(i), "pull enables");
    end
    gi <= 16'ha5c3;
    wr(pdoec_pkg::GP_IN_OFS, 32'hffff);
    rd(pdoec_pkg::GP_IN_OFS, 32'ha5c3, "gpio input");
    emu_mode <= 2'h1;
    settle();
    rd(pdoec_pkg::STATUS_OFS, 32'h1, "status off");
    emu_mode <= 2'h0;
    hold_req <= 1'b1;
    settle();
    rd(pdoec_pkg::STATUS_OFS, 32'h6, "status hold");
    // memory clock in hold: running with select 0; with select 1 clock 0 floats and clock 1 stays driven
    last = mc_o[0];
    n = 0;
    repeat (8)
    begin
      @(posedge core_clk);
      #1;
      n += int'(mc_o[0] != last);
      last = mc_o[0];
    end
    cmp(34'(n), 34'd4, "clock toggles in hold");
    wr(pdoec_pkg::CLK_HIZ_OFS, 32'h1);
    settle();
    cmp(34'(mc_oe), 34'h2, "clock float in hold");
    // random traffic over random software settings
    seed = xs(seed);
    {sel_r, dir_r} = seed;
    seed = xs(seed);
    {hiz_r, out_r} = seed[17:0];
    wr(pdoec_pkg::CLK_HIZ_OFS, 32'(hiz_r));
    wr(pdoec_pkg::GP_SEL_OFS, 32'(sel_r));
    wr(pdoec_pkg::GP_DIR_OFS, 32'(dir_r));
    wr(pdoec_pkg::GP_OUT_OFS, 32'(out_r));
    repeat (300)
    begin
      seed = xs(seed);
      @(posedge core_clk);
      {hold_req, emu_mode, emu_val, scan, int_out} <= seed[8:0];
      {bf_oe, gf_oe} <= {seed[30:15], seed[15:0]};
      {bf_o, gf_o, gi} <= {seed[15:0] ^ 16'h3c5a, seed[31:16], seed[23:8]};
      @(posedge core_clk);
      #1;
      cmp({mc_oe, bp_oe, gp_oe}, exp_oe(emu_mode == 2'h1, hold_req, bf_oe, gf_oe),
          "pad enables");
      if (!emu_mode[0]) cmp(34'({l1_oe, l0_oe}), 34'(scan), "emu direction");
      if (!emu_mode[0]) cmp(34'({l1_o, l0_o}), 34'(int_out), "emu drive");
      cmp(34'(bp_o), 34'(bf_o), "bus data");
      cmp(34'(gp_o), 34'((sel_r & out_r) | (~sel_r & gf_o)), "gpio data");
    end
    // reset in mid-run floats the pads and restores the defaults
    {emu_mode, hold_req, bf_oe} <= {3'h0, 16'hffff};
    @(posedge core_clk);
    nrst <= 1'b0;
    settle();
    cmp({mc_oe, bp_oe, gp_oe}, 34'h0, "pads in reset");
    cmp({30'h0, epu_en, pd_en, pu_en, hold_en}, 34'hf, "pulls in reset");
    @(posedge core_clk);
    nrst <= 1'b1;
    rd(pdoec_pkg::GP_SEL_OFS, 32'h0, "select after reset");
    print_verdict();
  end
endmodule : pdoec_bench
